// *** hw/blp_pkg.sv ***
package blp_pkg;
  localparam int CLK_KHZ      = 10000;
  localparam int TICK_MS      = 10;
  localparam int TICK_CYC     = TICK_MS * CLK_KHZ;
  localparam int SCP_BLANK_MS = 4;
  localparam int SCP_CYC      = SCP_BLANK_MS * CLK_KHZ;
  localparam int NSINK        = 7;
  localparam int LVL_W        = 7;
  localparam int NFLAG        = 5;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE   = 6'h01;
  localparam logic [5:0] IDX_FLAG   = 6'h02;
  localparam logic [5:0] IDX_MASK   = 6'h03;
  localparam logic [5:0] IDX_CFG    = 6'h04;
  localparam logic [5:0] IDX_GROUP  = 6'h05;
  localparam logic [5:0] IDX_FADE   = 6'h0F;
  localparam logic [5:0] IDX_SEN    = 6'h10;
  localparam logic [5:0] IDX_TIMER  = 6'h11;
  localparam logic [5:0] IDX_LVL0   = 6'h14;
  localparam logic [5:0] IDX_FILT1  = 6'h1B;
  localparam logic [5:0] IDX_FILT2  = 6'h1C;
  localparam logic [5:0] IDX_STATUS = 6'h25;
  localparam logic [31:0] REG_RST   = 32'h0000_0000;
  // Field positions
  localparam int MODE_AUTO  = 1;
  localparam int MODE_ACT   = 5;
  localparam int CFG_SEC    = 2;
  localparam int CFG_LVL    = 4;
  localparam int FADE_OUT   = 4;
  localparam int FADE_LAW   = 8;
  localparam int TMR_OFF    = 2;
  localparam int F_MAIN     = 0;
  localparam int F_SECOND   = 1;
  localparam int F_OVP      = 2;
  localparam int F_TSD      = 3;
  localparam int F_SHORT    = 4;
  localparam logic [1:0] LVL_DAY    = 2'h0;
  localparam logic [1:0] LVL_OFFICE = 2'h1;
  localparam logic [1:0] LVL_DARK   = 2'h2;
  // Blink and filter times in ms, counted in 10 ms ticks
  localparam int ON_MS0 = 200;
  localparam int ON_MS1 = 600;
  localparam int ON_MS2 = 800;
  localparam int ON_MS3 = 1200;
  localparam int OFF_MS1 = 600;
  localparam int OFF_MS2 = 1200;
  localparam int OFF_MS3 = 1800;
  localparam int FLT_MS0 = 80;
  localparam int FLT_MS7 = 10000;

  typedef enum {ST_STANDBY, ST_START, ST_RUN, ST_SHORT, ST_THERM} blp_state_e;

  function automatic logic [7:0] blp_on_ticks(input logic [1:0] s);
    case (s)
      2'h0:    return 8'(ON_MS0 / TICK_MS);
      2'h1:    return 8'(ON_MS1 / TICK_MS);
      2'h2:    return 8'(ON_MS2 / TICK_MS);
      default: return 8'(ON_MS3 / TICK_MS);
    endcase
  endfunction

  function automatic logic [7:0] blp_off_ticks(input logic [1:0] s);
    case (s)
      2'h1:    return 8'(OFF_MS1 / TICK_MS);
      2'h2:    return 8'(OFF_MS2 / TICK_MS);
      default: return 8'(OFF_MS3 / TICK_MS);
    endcase
  endfunction

  // Doubling steps from 80 ms, top setting capped at 10 s
  function automatic logic [9:0] blp_filt_ticks(input logic [2:0] s);
    if (s == 3'h7) return 10'(FLT_MS7 / TICK_MS);
    return 10'((FLT_MS0 / TICK_MS) << s);
  endfunction
endpackage

// *** hw/blp_sink_chan.sv ***
`timescale 1ns/1ns
// One independent sink: blink phases and shared-rate fading
module blp_sink_chan (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick,
  // Settings
  input  wire logic             run,
  input  wire logic [6:0]       level,
  input  wire logic [1:0]       on_sel,
  input  wire logic [1:0]       off_sel,
  input  wire logic [3:0]       fade_in,
  input  wire logic [3:0]       fade_out,
  input  wire logic             law,
  // Drive
  output logic      [6:0]       current
);
  import blp_pkg::*;

  logic       phase_on_reg;
  logic [7:0] tcnt_reg;
  logic [3:0] fcnt_reg;
  logic [6:0] lvl_reg;
  logic [6:0] target;
  logic [3:0] rate;
  logic       blink;
  logic [13:0] sq;

  assign blink  = off_sel != 2'h0;
  // Disabled during the off phase the target is already zero
  assign target = (run && (phase_on_reg || !blink)) ? level : 7'h00;
  assign rate   = (lvl_reg < target) ? fade_in : fade_out;
  assign sq     = lvl_reg * lvl_reg;

  // Blink phase timer; restarts in the on phase at each enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_on_reg <= 1'b1;
      tcnt_reg     <= 8'h00;
    end else if (!run || !blink) begin
      phase_on_reg <= 1'b1;
      tcnt_reg     <= 8'h00;
    end else if (tick) begin
      if (phase_on_reg && tcnt_reg + 8'h01 >= blp_on_ticks(on_sel)) begin
        phase_on_reg <= 1'b0;
        tcnt_reg     <= 8'h00;
      end else if (!phase_on_reg &&
                   tcnt_reg + 8'h01 >= blp_off_ticks(off_sel)) begin
        phase_on_reg <= 1'b1;
        tcnt_reg     <= 8'h00;
      end else begin
        tcnt_reg <= tcnt_reg + 8'h01;
      end
    end
  end

  // Fade: one level step every rate ticks, rate zero jumps at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg  <= 7'h00;
      fcnt_reg <= 4'h0;
    end else if (lvl_reg == target) begin
      fcnt_reg <= 4'h0;
    end else if (rate == 4'h0) begin
      lvl_reg <= target;
    end else if (tick) begin
      if (fcnt_reg + 4'h1 >= rate) begin
        fcnt_reg <= 4'h0;
        lvl_reg  <= (lvl_reg < target) ? lvl_reg + 7'h01 : lvl_reg - 7'h01;
      end else begin
        fcnt_reg <= fcnt_reg + 4'h1;
      end
    end
  end

  // Square law trades low-end resolution for perceived smoothness
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) current <= 7'h00;
    else          current <= law ? sq[13:7] : lvl_reg;
  end

  a_off_phase_dark: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!phase_on_reg && lvl_reg == 7'h00) |=> lvl_reg == 7'h00)
    else $error("sink lit during off phase");
endmodule // blp_sink_chan

// *** hw/blp_ctrl.sv ***
`timescale 1ns/1ns
// Backlight controller: auto level, sinks, faults and flags over APB
module blp_ctrl #(
  parameter int TICK_CYC = blp_pkg::TICK_CYC,
  parameter int SCP_CYC  = blp_pkg::SCP_CYC
) (
  // APB slave
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Ambient comparators, main then second sensor
  input  wire logic                        office_cmp_raw,
  input  wire logic                        dark_cmp_raw,
  input  wire logic                        office2_cmp_raw,
  input  wire logic                        dark2_cmp_raw,
  // Analog fault and status indications
  input  wire logic                        short_detect,
  input  wire logic                        ovp_trip,
  input  wire logic                        clamp_active,
  input  wire logic                        temp_hot,
  input  wire logic                        temp_above_rec,
  // Power and sink drive
  output logic                             pump_en,
  output logic                             soft_start,
  output logic      [1:0]                  level_select,
  output logic      [blp_pkg::NSINK-1:0]   backlight_member,
  output logic      [blp_pkg::NSINK*blp_pkg::LVL_W-1:0] sink_current,
  // Interrupt pin
  output logic                             irq_out_n
);
  import blp_pkg::*;

  // Checks below share one clock and stay idle during reset
  default clocking cb_main @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic idx_mapped(input logic [5:0] i);
    return i == IDX_MODE || i == IDX_FLAG || i == IDX_MASK ||
           i == IDX_CFG || i == IDX_GROUP || i == IDX_FADE ||
           i == IDX_SEN || i == IDX_TIMER || i == IDX_FILT1 ||
           i == IDX_FILT2 || i == IDX_STATUS ||
           (i >= IDX_LVL0 && i < IDX_LVL0 + 6'(NSINK));
  endfunction

  logic [5:0]       idx;
  logic             acc;
  logic             ack_reg;
  logic             err_reg;
  logic             wr_en;
  logic [31:0]      rd_val;
  logic             auto_reg;
  logic             act_reg;
  logic             sec_reg;
  logic [4:0]       flag_reg;
  logic [4:0]       mask_reg;
  logic [4:0]       flag_set;
  logic [4:0]       flag_clr;
  logic [6:0]       group_reg;
  logic [8:0]       fade_reg;
  logic [6:0]       sen_reg;
  logic [15:0]      timer_reg;
  logic [6:0]       lvl_reg [0:NSINK-1];
  logic [2:0]       filt1_reg;
  logic [2:0]       filt2_reg;
  logic [19:0]      tick_cnt_reg;
  logic             tick;
  logic [3:0]       cmp_raw;
  logic [3:0]       cmp_out;
  logic [3:0]       cmp_d_reg;
  logic             office_cmp_out;
  logic             dark_cmp_out;
  logic             ovp_d_reg;
  logic [19:0]      scp_cnt_reg;
  logic             act_wr1;
  logic             irq_n_reg;
  blp_state_e       state_reg;
  blp_state_e       state_next;

  // APB: one wait state so read data leave a flip-flop
  assign idx     = paddr[7:2];
  assign acc     = psel && penable;
  assign pready  = ack_reg;
  assign pslverr = ack_reg && err_reg;
  assign wr_en   = acc && ack_reg && pwrite && !err_reg;
  assign act_wr1 = wr_en && idx == IDX_MODE && pwdata[MODE_ACT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata  <= REG_RST;
    end else begin
      ack_reg <= acc && !ack_reg;
      if (acc && !ack_reg) begin
        err_reg <= !idx_mapped(idx);
        prdata  <= rd_val;
      end
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      IDX_MODE: begin
        rd_val[MODE_AUTO] = auto_reg;
        rd_val[MODE_ACT]  = act_reg;
      end
      IDX_FLAG:   rd_val[4:0] = flag_reg;
      IDX_MASK:   rd_val[4:0] = mask_reg;
      IDX_CFG: begin
        rd_val[CFG_SEC]           = sec_reg;
        rd_val[CFG_LVL+1:CFG_LVL] = level_select;
      end
      IDX_GROUP:  rd_val[6:0]  = group_reg;
      IDX_FADE:   rd_val[8:0]  = fade_reg;
      IDX_SEN:    rd_val[6:0]  = sen_reg;
      IDX_TIMER:  rd_val[15:0] = timer_reg;
      IDX_FILT1:  rd_val[2:0]  = filt1_reg;
      IDX_FILT2:  rd_val[2:0]  = filt2_reg;
      IDX_STATUS: rd_val[7:0]  = {clamp_active, pump_en, soft_start,
                                  state_reg == ST_RUN, cmp_out};
      default: begin
        if (idx >= IDX_LVL0 && idx < IDX_LVL0 + 6'(NSINK))
          rd_val[6:0] = lvl_reg[3'(idx - IDX_LVL0)];
      end
    endcase
  end

  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_reg  <= REG_RST[0];
      sec_reg   <= REG_RST[0];
      mask_reg  <= REG_RST[4:0];
      group_reg <= REG_RST[6:0];
      fade_reg  <= REG_RST[8:0];
      sen_reg   <= REG_RST[6:0];
      timer_reg <= REG_RST[15:0];
      filt1_reg <= REG_RST[2:0];
      filt2_reg <= REG_RST[2:0];
      for (int k = 0; k < NSINK; k++) lvl_reg[k] <= REG_RST[6:0];
    end else if (wr_en) begin
      case (idx)
        IDX_MODE:  auto_reg  <= pwdata[MODE_AUTO];
        IDX_CFG:   sec_reg   <= pwdata[CFG_SEC];
        IDX_MASK:  mask_reg  <= pwdata[4:0];
        IDX_GROUP: group_reg <= pwdata[6:0];
        IDX_FADE:  fade_reg  <= pwdata[8:0];
        IDX_SEN:   sen_reg   <= pwdata[6:0];
        IDX_TIMER: timer_reg <= pwdata[15:0];
        IDX_FILT1: filt1_reg <= pwdata[2:0];
        IDX_FILT2: filt2_reg <= pwdata[2:0];
        default: begin
          if (idx >= IDX_LVL0 && idx < IDX_LVL0 + 6'(NSINK))
            lvl_reg[3'(idx - IDX_LVL0)] <= pwdata[6:0];
        end
      endcase
    end
  end

  // Active bit: host writes it; thermal shutdown holds it clear,
  // so a write while still hot cannot leave a stale active bit behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      act_reg <= REG_RST[0];
    else if (state_next == ST_THERM)
      act_reg <= 1'b0;
    else if (wr_en && idx == IDX_MODE)
      act_reg <= pwdata[MODE_ACT];
  end

  // 10 ms timebase for filters, blink and fade
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 20'h00000;
      tick         <= 1'b0;
    end else if (tick_cnt_reg == 20'(TICK_CYC - 1)) begin
      tick_cnt_reg <= 20'h00000;
      tick         <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 20'h00001;
      tick         <= 1'b0;
    end
  end

  // Comparator filters; analog hysteresis already shapes the raw edges
  assign cmp_raw = {dark2_cmp_raw, office2_cmp_raw,
                    dark_cmp_raw, office_cmp_raw};
  for (genvar g = 0; g < 4; g++) begin : g_flt
    logic [9:0] cnt_reg;
    logic       out_reg;
    logic [9:0] lim;
    assign lim = blp_filt_ticks(g < 2 ? filt1_reg : filt2_reg);
    // A glitch shorter than the filter time resets the count
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= 10'h000;
        out_reg <= 1'b0;
      end else if (cmp_raw[g] == out_reg) begin
        cnt_reg <= 10'h000;
      end else if (tick) begin
        if (cnt_reg + 10'h001 >= lim) begin
          out_reg <= cmp_raw[g];
          cnt_reg <= 10'h000;
        end else begin
          cnt_reg <= cnt_reg + 10'h001;
        end
      end
    end
    assign cmp_out[g] = out_reg;
  end

  // Auto level follows the selected sensor; dark outranks office
  assign office_cmp_out = sec_reg ? cmp_out[2] : cmp_out[0];
  assign dark_cmp_out   = sec_reg ? cmp_out[3] : cmp_out[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      level_select <= LVL_DAY;
    else if (auto_reg) begin
      if (dark_cmp_out)
        level_select <= LVL_DARK;
      else if (office_cmp_out)
        level_select <= LVL_OFFICE;
      else
        level_select <= LVL_DAY;
    end else if (wr_en && idx == IDX_CFG)
      level_select <= pwdata[CFG_LVL+1:CFG_LVL];
  end

  // Power state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY: if (act_reg) state_next = ST_START;
      ST_START:   if (scp_cnt_reg == 20'h00000) state_next = ST_RUN;
      ST_RUN: begin
        if (!act_reg) state_next = ST_STANDBY;
        else if (short_detect) state_next = ST_SHORT;
      end
      ST_SHORT:   if (act_wr1) state_next = ST_START;
      ST_THERM:   if (act_wr1 && !temp_above_rec) state_next = ST_START;
      default:    state_next = ST_STANDBY;
    endcase
    if (temp_hot && state_reg != ST_THERM)
      state_next = ST_THERM;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_reg <= ST_STANDBY;
    else          state_reg <= state_next;
  end

  // Short sensing blank: reloaded at each start or restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      scp_cnt_reg <= 20'(SCP_CYC - 1);
    else if (state_reg != ST_START)
      scp_cnt_reg <= 20'(SCP_CYC - 1);
    else if (scp_cnt_reg != 20'h00000)
      scp_cnt_reg <= scp_cnt_reg - 20'h00001;
  end

  // Pump runs in start and run only and stops on overvoltage; clamp regulation is not a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_en    <= 1'b0;
      soft_start <= 1'b0;
    end else begin
      pump_en    <= (state_next == ST_START || state_next == ST_RUN) &&
                    !ovp_trip;
      soft_start <= state_next == ST_START;
    end
  end

  // Flag sources; set beats a same-cycle clear
  assign flag_set[F_MAIN]   = cmp_out[1:0] != cmp_d_reg[1:0];
  assign flag_set[F_SECOND] = cmp_out[3:2] != cmp_d_reg[3:2];
  assign flag_set[F_OVP]    = ovp_trip && !ovp_d_reg;
  assign flag_set[F_TSD]    = (temp_hot && state_reg != ST_THERM) ||
                              (state_reg == ST_THERM &&
                               temp_above_rec);
  assign flag_set[F_SHORT]  = state_reg == ST_RUN && act_reg &&
                              short_detect;
  assign flag_clr = (wr_en && idx == IDX_FLAG) ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg  <= REG_RST[4:0];
      cmp_d_reg <= 4'h0;
      ovp_d_reg <= 1'b0;
    end else begin
      flag_reg  <= (flag_reg & ~flag_clr) | flag_set;
      cmp_d_reg <= cmp_out;
      ovp_d_reg <= ovp_trip;
    end
  end

  // Pin is registered so a masked flag never glitches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_n_reg <= 1'b1;
    else          irq_n_reg <= ~|(flag_reg & mask_reg);
  end
  assign irq_out_n = irq_n_reg;

  // Sinks: independent ones run only while the supply is up
  assign backlight_member = ~group_reg;
  for (genvar s = 0; s < NSINK; s++) begin : g_sink
    blp_sink_chan u_chan (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (tick),
      .run      (sen_reg[s] && group_reg[s] && state_reg == ST_RUN),
      .level    (lvl_reg[s]),
      .on_sel   (timer_reg[1:0]),
      .off_sel  (timer_reg[TMR_OFF+2*s+1:TMR_OFF+2*s]),
      .fade_in  (fade_reg[3:0]),
      .fade_out (fade_reg[FADE_OUT+3:FADE_OUT]),
      .law      (fade_reg[FADE_LAW]),
      .current  (sink_current[LVL_W*s+LVL_W-1:LVL_W*s])
    );
  end

  a_auto_dark: assert property (
    (auto_reg && dark_cmp_out) |=> level_select == LVL_DARK)
    else $error("dark not selected");
  a_auto_office: assert property (
    (auto_reg && office_cmp_out && !dark_cmp_out)
      |=> level_select == LVL_OFFICE)
    else $error("office not selected");
  a_manual_hold: assert property (
    (!auto_reg && !(wr_en && idx == IDX_CFG))
      |=> $stable(level_select))
    else $error("manual level changed");
  a_irq_pin: assert property (
    1'b1 |=> irq_out_n == !$past(|(flag_reg & mask_reg)))
    else $error("irq pin wrong");
  a_flag_keep: assert property (
    ($past(flag_reg) & ~flag_reg & ~$past(flag_clr)) == 5'h00)
    else $error("flag lost without clear");
  a_ovp_flag: assert property (
    $rose(ovp_trip) |=> flag_reg[F_OVP] && !pump_en)
    else $error("overvoltage not handled");
  a_scp_blank: assert property (
    (state_reg == ST_START && scp_cnt_reg != 20'h00000)
      |=> state_reg != ST_RUN)
    else $error("run entered during short blank");
  a_tsd_rearm: assert property (
    (state_reg == ST_THERM && temp_above_rec)
      |=> flag_reg[F_TSD] && !act_reg)
    else $error("thermal flag not held");
  a_light_edge: assert property (
    ($changed(cmp_out[0]) || $changed(cmp_out[1]))
      |=> flag_reg[F_MAIN])
    else $error("main light flag missed");
endmodule // blp_ctrl

// *** dv/blp_afe_model.sv ***
`timescale 1ns/1ns
// Light sensor front end: two photosensors seen through shared trip levels
module blp_afe_model (
  // Clock and commanded light
  input  wire logic pclk,
  input  wire logic dim_req,
  input  wire logic dark_req,
  // Comparator levels, high while light is below trip
  output logic      office_out,
  output logic      dark_out,
  output logic      office2_out,
  output logic      dark2_out
);
  // Both sensors share thresholds, so they see the same light here
  always_ff @(posedge pclk) begin
    office_out  <= dim_req;
    dark_out    <= dark_req;
    office2_out <= dim_req;
    dark2_out   <= dark_req;
  end
endmodule // blp_afe_model

// *** dv/backlight_auto_level_blink_fault_irq_tb_top.sv ***
`timescale 1ns/1ns
// Bench: APB host plus light and fault stimulus
module backlight_auto_level_blink_fault_irq_tb_top;
  import blp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ofc, drk, ofc2, drk2, dim, dark, sht, overvolt_protect, hot, rec, clm;
  logic pump_en, soft_start, irq_out_n;
  logic [1:0] level_select;
  logic [6:0] bl;
  logic [48:0] snk;
  int mismatches, tests_run;
  blp_afe_model blp_afe_model_inst (.pclk(pclk), .dim_req(dim),
    .dark_req(dark), .office_out(ofc), .dark_out(drk),
    .office2_out(ofc2), .dark2_out(drk2));
  blp_ctrl #(.TICK_CYC(10), .SCP_CYC(20)) blp_ctrl_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .office_cmp_raw(ofc), .dark_cmp_raw(drk),
    .office2_cmp_raw(ofc2), .dark2_cmp_raw(drk2), .short_detect(sht),
    .ovp_trip(overvolt_protect), .clamp_active(clm), .temp_hot(hot),
    .temp_above_rec(rec), .pump_en(pump_en), .soft_start(soft_start),
    .level_select(level_select), .backlight_member(bl),
    .sink_current(snk), .irq_out_n(irq_out_n));
  // Clock at 10 MHz
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic ap(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (n >= 50) begin
      mismatches++;
      give_verdict();
    end
    chk({31'h0, pslverr}, {31'h0, a == 8'hFC});
    psel <= 0; penable <= 0;
  endtask
  // Waits long enough for the 80 ms filter at 10-cycle ticks
  task automatic lvl(input logic dm, input logic dk);
    dim <= dm; dark <= dk;
    repeat (150) @(posedge pclk);
  endtask
  task automatic sc_auto();
    ap(1, 8'h04, 32'h2);
    lvl(1, 1);
    chk({30'h0, level_select}, {30'h0, LVL_DARK});
    ap(0, 8'h08, 0);
    chk(rd, 32'h3);
    ap(1, 8'h08, 0);
    ap(0, 8'h08, 0);
    chk(rd, 32'h3);
    ap(1, 8'h0C, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_out_n}, 32'h0);
    ap(1, 8'h08, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_out_n}, 32'h1);
    lvl(1, 0);
    chk({30'h0, level_select}, {30'h0, LVL_OFFICE});
    lvl(0, 0);
    chk({30'h0, level_select}, {30'h0, LVL_DAY});
    ap(0, 8'hFC, 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic sc_manual();
    ap(1, 8'h04, 32'h0);
    ap(1, 8'h10, 32'h20);
    repeat (2) @(posedge pclk);
    chk({30'h0, level_select}, {30'h0, LVL_DARK});
  endtask
  task automatic sc_faults();
    ap(1, 8'h08, 32'h1F);
    ap(1, 8'h04, 32'h20);
    repeat (40) @(posedge pclk);
    sht <= 1;
    repeat (3) @(posedge pclk);
    sht <= 0;
    ap(0, 8'h08, 0);
    chk(rd & 32'h10, 32'h10);
    ap(1, 8'h04, 32'h20);
    repeat (2) @(posedge pclk);
    chk({31'h0, soft_start}, 32'h1);
    repeat (40) @(posedge pclk);
    overvolt_protect <= 1;
    repeat (3) @(posedge pclk);
    chk({31'h0, pump_en}, 32'h0);
    overvolt_protect <= 0;
    ap(0, 8'h08, 0);
    chk(rd & 32'h4, 32'h4);
    hot <= 1; rec <= 1;
    repeat (3) @(posedge pclk);
    hot <= 0;
    ap(1, 8'h08, 32'h1F);
    ap(0, 8'h08, 0);
    chk(rd & 32'h8, 32'h8);
    rec <= 0;
    ap(1, 8'h08, 32'h1F);
    ap(0, 8'h08, 0);
    chk(rd & 32'h8, 32'h0);
  endtask
  // Sink 0 independent, 0.2 s on and 0.6 s off, instant fades
  task automatic sc_sink();
    clm <= 1;
    ap(1, 8'h04, 32'h20);
    ap(1, 8'h14, 32'h1);
    ap(1, 8'h3C, 32'h0);
    chk({25'h0, bl}, 32'h7E);
    ap(1, 8'h44, 32'h4);
    ap(1, 8'h50, 32'h40);
    ap(0, 8'h08, 0);
    chk(rd, 32'h0);
    ap(0, 8'h94, 0);
    chk(rd & 32'h80, 32'h80);
    clm <= 0;
    ap(1, 8'h40, 32'h1);
    repeat (150) @(posedge pclk);
    chk({25'h0, snk[6:0]}, 32'h40);
    chk({25'h0, snk[13:7]}, 32'h0);
    repeat (100) @(posedge pclk);
    chk({25'h0, snk[6:0]}, 32'h0);
    repeat (600) @(posedge pclk);
    chk({25'h0, snk[6:0]}, 32'h40);
    ap(1, 8'h40, 32'h0);
    repeat (3) @(posedge pclk);
    chk({25'h0, snk[6:0]}, 32'h0);
    repeat (300) @(posedge pclk);
    chk({25'h0, snk[6:0]}, 32'h0);
  endtask
  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    mismatches = 0; tests_run = 0;
    presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; dim = 0; dark = 0;
    sht = 0; overvolt_protect = 0; hot = 0; rec = 0; clm = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({25'h0, bl}, 32'h7F);
    chk({31'h0, irq_out_n}, 32'h1);
    sc_auto();
    sc_manual();
    sc_faults();
    sc_sink();
    give_verdict();
  end
endmodule // backlight_auto_level_blink_fault_irq_tb_top
